/* logic/elrh_pkg.sv */
/*
  Shared constants for the extended log read handler: command fields,
  log addresses, sector layouts, status bits and register offsets.
  Assumes a 32-bit AXI4-Lite register bus and byte-wide log streaming.
*/
package elrh_pkg;
  localparam logic [7:0] CMD_LOG_READ = 8'h2F;
  localparam logic [7:0] LOG_DIR = 8'h00;
  localparam logic [7:0] LOG_ERR = 8'h03;
  localparam logic [7:0] LOG_SELFTEST = 8'h07;
  localparam logic [7:0] LOG_QERR = 8'h10;
  localparam logic [7:0] LOG_PHY = 8'h11;
  localparam logic [7:0] LOG_HOST_LO = 8'h80;
  localparam logic [7:0] LOG_HOST_HI = 8'h9F;
  localparam logic [15:0] HOST_LOG_SECTORS = 16'h0010;
  localparam logic [15:0] ONE_SECTOR = 16'h0001;
  localparam logic [15:0] DIR_VERSION = 16'h0001;
  localparam logic [7:0] ERR_VERSION = 8'h01;
  localparam logic [8:0] LAST_BYTE = 9'h1FF;
  localparam logic [8:0] ERR_IDX_LO = 9'h002;
  localparam logic [8:0] ERR_IDX_HI = 9'h003;
  localparam logic [8:0] ERR_ENTRY0 = 9'h004;
  localparam logic [8:0] ERR_ENTRY_END = 9'h1F4;
  localparam logic [8:0] ERR_CNT_LO = 9'h1F4;
  localparam logic [8:0] ERR_CNT_HI = 9'h1F5;
  localparam logic [6:0] ENTRY_BYTES = 7'h7C;
  localparam logic [6:0] ENT_ERRREG = 7'h5B;
  localparam logic [6:0] ENT_STATUS = 7'h65;
  localparam logic [2:0] ERR_SLOTS = 3'h4;
  // Status and error flag bit positions
  localparam int ST_ERR = 0;
  localparam int ST_DRQ = 3;
  localparam int ST_DSC = 4;
  localparam int ST_RDY = 6;
  localparam int ST_BSY = 7;
  localparam int ER_ABT = 2;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERRINFO = 8'h08;
  localparam logic [7:0] REG_PHY = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } elrh_state_t;
endpackage

/* logic/elrh_top.sv */
/*
  Extended log read handler: decodes the log read command, validates it,
  streams 512-byte log sectors with one interrupt per block, keeps the
  error log ring and the physical-layer event counter.
  Assumes the command fields arrive on a one-cycle strobe and the host side
  drains bytes with valid/ready; registers sit behind AXI4-Lite.
*/
`timescale 1ns/10ps
module elrh_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command block from the link
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic cmd_phy_reset,
  input wire logic [7:0] cmd_count_cur,
  input wire logic [7:0] cmd_count_prev,
  input wire logic [7:0] cmd_addr_lo,
  input wire logic [7:0] cmd_addr_mid_cur,
  input wire logic [7:0] cmd_addr_mid_prev,
  // Device error events
  input wire logic dev_error,
  input wire logic dev_error_faulty_cmd,
  input wire logic phy_event,
  // Log data stream to the host
  output logic log_valid,
  output logic [7:0] log_data,
  output logic log_last,
  input wire logic log_ready,
  output logic host_intr,
  output logic [7:0] command_status_flags,
  output logic [7:0] command_error_flags,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  elrh_pkg::elrh_state_t state_q;
  logic [7:0] log_q;
  logic [15:0] sect_q, left_q;
  logic [8:0] byte_q;
  logic [7:0] sum_q;
  logic phy_clr_q;
  logic [7:0] status_q, error_q;
  logic [2:0] err_idx_q;
  logic [15:0] err_cnt_q;
  logic [3:0] slot_used_q;
  logic [7:0] slot_err_q [4];
  logic [7:0] slot_stat_q [4];
  logic [CNT_W-1:0] phy_cnt_q;
  logic [3:0] enable_q;
  logic [7:0] byte_d;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Sector size of each supported log, zero for absent logs
  function automatic logic [15:0] log_size(input logic [7:0] a);
    if (a == elrh_pkg::LOG_DIR || a == elrh_pkg::LOG_ERR || a == elrh_pkg::LOG_SELFTEST ||
        a == elrh_pkg::LOG_QERR || a == elrh_pkg::LOG_PHY) begin
      return elrh_pkg::ONE_SECTOR;
    end else if (a >= elrh_pkg::LOG_HOST_LO && a <= elrh_pkg::LOG_HOST_HI) begin
      return elrh_pkg::HOST_LOG_SECTORS;
    end else begin
      return 16'h0000;
    end
  endfunction

  // Feature-set enable per log group, written by software
  function automatic logic log_enabled(input logic [7:0] a, input logic [3:0] en);
    if (a == elrh_pkg::LOG_ERR || a == elrh_pkg::LOG_SELFTEST) begin
      return en[0];
    end else if (a == elrh_pkg::LOG_QERR) begin
      return en[1];
    end else if (a == elrh_pkg::LOG_PHY) begin
      return en[2];
    end else if (a >= elrh_pkg::LOG_HOST_LO) begin
      return en[3];
    end else begin
      return 1'b1;
    end
  endfunction

  wire [15:0] req_count = {cmd_count_prev, cmd_count_cur};
  wire [15:0] req_sect = {cmd_addr_mid_prev, cmd_addr_mid_cur};
  wire [15:0] req_size = log_size(cmd_addr_lo);
  wire cmd_ok = req_size != 16'h0000 && log_enabled(cmd_addr_lo, enable_q) &&
    req_count != 16'h0000 && req_sect < req_size &&
    {1'b0, req_count} <= {1'b0, req_size} - {1'b0, req_sect};
  wire cmd_go = cmd_valid && cmd_opcode == elrh_pkg::CMD_LOG_READ && state_q == elrh_pkg::ST_IDLE;
  wire beat = log_valid && log_ready;
  wire [8:0] in_err = byte_q - elrh_pkg::ERR_ENTRY0;
  wire [6:0] ent_off = 7'(in_err % 9'(elrh_pkg::ENTRY_BYTES));
  wire [1:0] ent_num = 2'(in_err / 9'(elrh_pkg::ENTRY_BYTES));

  // Directory entry for the log whose address is half the byte offset
  wire [15:0] dir_size = log_size(byte_q[8:1]);

  // Byte generator for the sector at byte_q; reserved bytes read zero.
  // The directory has no checksum: its last byte is the high byte of the count of log FFh.
  always_comb begin
    byte_d = 8'h00;
    if (byte_q == elrh_pkg::LAST_BYTE && log_q != elrh_pkg::LOG_QERR &&
        log_q != elrh_pkg::LOG_DIR) begin
      byte_d = 8'(8'h00 - sum_q);
    end else if (log_q == elrh_pkg::LOG_DIR && sect_q == 16'h0000) begin
      if (byte_q == 9'h000) begin
        byte_d = elrh_pkg::DIR_VERSION[7:0];
      end else if (byte_q == 9'h001) begin
        byte_d = elrh_pkg::DIR_VERSION[15:8];
      end else begin
        byte_d = byte_q[0] ? dir_size[15:8] : dir_size[7:0];
      end
    end else if (log_q == elrh_pkg::LOG_ERR) begin
      if (byte_q == 9'h000) begin
        byte_d = elrh_pkg::ERR_VERSION;
      end else if (byte_q == elrh_pkg::ERR_IDX_LO) begin
        byte_d = {5'h00, err_idx_q};
      end else if (byte_q == elrh_pkg::ERR_CNT_LO) begin
        byte_d = err_cnt_q[7:0];
      end else if (byte_q == elrh_pkg::ERR_CNT_HI) begin
        byte_d = err_cnt_q[15:8];
      end else if (byte_q >= elrh_pkg::ERR_ENTRY0 && byte_q < elrh_pkg::ERR_ENTRY_END &&
                   slot_used_q[ent_num]) begin
        if (ent_off == elrh_pkg::ENT_ERRREG) begin
          byte_d = slot_err_q[ent_num];
        end else if (ent_off == elrh_pkg::ENT_STATUS) begin
          byte_d = slot_stat_q[ent_num];
        end
      end
    end else if (log_q == elrh_pkg::LOG_SELFTEST && byte_q == 9'h000) begin
      byte_d = elrh_pkg::ERR_VERSION; // empty 48-bit format log, revision only
    end else if (log_q == elrh_pkg::LOG_PHY && byte_q[8:1] == 8'h01) begin
      byte_d = byte_q[0] ? 8'(phy_cnt_q >> 8) : 8'(phy_cnt_q);
    end
  end

  // Command sequencer: one DRQ block per sector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= elrh_pkg::ST_IDLE;
      log_q <= 8'h00;
      sect_q <= 16'h0000;
      left_q <= 16'h0000;
      byte_q <= 9'h000;
      sum_q <= 8'h00;
      phy_clr_q <= 1'b0;
      log_data <= 8'h00;
      host_intr <= 1'b0;
    end else begin
      host_intr <= 1'b0;
      case (state_q)
        elrh_pkg::ST_IDLE: begin
          if (cmd_go && cmd_ok) begin
            log_q <= cmd_addr_lo;
            sect_q <= req_sect;
            left_q <= req_count;
            byte_q <= 9'h000;
            sum_q <= 8'h00;
            phy_clr_q <= cmd_phy_reset && cmd_addr_lo == elrh_pkg::LOG_PHY;
            state_q <= elrh_pkg::ST_WAIT;
          end
        end
        elrh_pkg::ST_WAIT: begin
          // One cycle to register the byte so data comes from a flip-flop
          log_data <= byte_d;
          state_q <= elrh_pkg::ST_SEND;
        end
        elrh_pkg::ST_SEND: begin
          if (beat) begin
            sum_q <= sum_q + log_data;
            byte_q <= byte_q + 9'h001;
            state_q <= elrh_pkg::ST_WAIT;
            if (byte_q == elrh_pkg::LAST_BYTE) begin
              host_intr <= 1'b1;
              sum_q <= 8'h00;
              sect_q <= sect_q + 16'h0001;
              left_q <= left_q - 16'h0001;
              if (left_q == 16'h0001) begin
                state_q <= elrh_pkg::ST_IDLE;
                phy_clr_q <= 1'b0;
              end
            end
          end
        end
        default: state_q <= elrh_pkg::ST_IDLE;
      endcase
    end
  end

  assign log_valid = state_q == elrh_pkg::ST_SEND;
  assign log_last = log_valid && byte_q == elrh_pkg::LAST_BYTE;
  wire phy_clear = log_last && log_ready && left_q == 16'h0001 && phy_clr_q;

  // Task file flags; abort leaves no data phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 8'h00;
      error_q <= 8'h00;
    end else if (cmd_go && !cmd_ok) begin
      status_q <= 8'h00;
      status_q[elrh_pkg::ST_RDY] <= 1'b1;
      status_q[elrh_pkg::ST_ERR] <= 1'b1;
      error_q <= 8'h00;
      error_q[elrh_pkg::ER_ABT] <= 1'b1;
    end else if (cmd_go) begin
      status_q <= 8'h00;
      status_q[elrh_pkg::ST_BSY] <= 1'b1;
      error_q <= 8'h00;
    end else if (state_q != elrh_pkg::ST_IDLE) begin
      status_q <= 8'h00;
      status_q[elrh_pkg::ST_DRQ] <= 1'b1;
    end else if (status_q[elrh_pkg::ST_DRQ] || status_q[elrh_pkg::ST_BSY]) begin
      status_q <= 8'h00;
      status_q[elrh_pkg::ST_RDY] <= 1'b1;
      status_q[elrh_pkg::ST_DSC] <= 1'b1;
    end
  end
  assign command_status_flags = status_q;
  assign command_error_flags = error_q;

  // Physical-layer event counter; an event in the clearing cycle is kept as a count of 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_cnt_q <= '0;
    end else if (phy_event) begin
      phy_cnt_q <= phy_clear ? CNT_W'(1) : phy_cnt_q + CNT_W'(1);
    end else if (phy_clear) begin
      phy_cnt_q <= '0;
    end
  end

  // Error log ring; faulty-command errors are not recorded
  wire log_err = dev_error && !dev_error_faulty_cmd;
  wire [2:0] next_idx = err_idx_q == elrh_pkg::ERR_SLOTS ? 3'h1 : err_idx_q + 3'h1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_idx_q <= 3'h0;
      err_cnt_q <= 16'h0000;
      slot_used_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        slot_err_q[i] <= 8'h00;
        slot_stat_q[i] <= 8'h00;
      end
    end else if (log_err) begin
      err_idx_q <= next_idx;
      slot_used_q[2'(next_idx - 3'h1)] <= 1'b1;
      slot_err_q[2'(next_idx - 3'h1)] <= error_q;
      slot_stat_q[2'(next_idx - 3'h1)] <= status_q;
      if (err_cnt_q != 16'hFFFF) begin
        err_cnt_q <= err_cnt_q + 16'h0001;
      end
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= elrh_pkg::RESP_OKAY;
      enable_q <= 4'hF;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q[7:2] == elrh_pkg::REG_CTRL[7:2]) begin
          s_axi_bresp <= elrh_pkg::RESP_OKAY;
          if (w_strb_q[0]) begin
            enable_q <= w_data_q[3:0];
          end
        end else begin
          s_axi_bresp <= elrh_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= elrh_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= elrh_pkg::RESP_OKAY;
      if (s_axi_araddr[7:2] == elrh_pkg::REG_CTRL[7:2]) begin
        s_axi_rdata <= {28'h000_0000, enable_q};
      end else if (s_axi_araddr[7:2] == elrh_pkg::REG_STATUS[7:2]) begin
        s_axi_rdata <= {14'h0000, state_q, error_q, status_q};
      end else if (s_axi_araddr[7:2] == elrh_pkg::REG_ERRINFO[7:2]) begin
        s_axi_rdata <= {13'h0000, err_idx_q, err_cnt_q};
      end else if (s_axi_araddr[7:2] == elrh_pkg::REG_PHY[7:2]) begin
        s_axi_rdata <= 32'(phy_cnt_q);
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= elrh_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  chk_abort_no_data: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && !cmd_ok |=> state_q == elrh_pkg::ST_IDLE && error_q[elrh_pkg::ER_ABT])
    else $error("aborted command started data");
  chk_start_read: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_ok |=> state_q == elrh_pkg::ST_WAIT && sect_q == $past(req_sect))
    else $error("valid read did not start");
  chk_intr_block: assert property (@(posedge aclk) disable iff (!aresetn)
    log_last && log_ready |=> host_intr)
    else $error("no interrupt after block");
  chk_intr_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    host_intr |-> $past(log_last && log_ready))
    else $error("spurious interrupt");
  chk_idx_range: assert property (@(posedge aclk) disable iff (!aresetn)
    err_idx_q <= elrh_pkg::ERR_SLOTS)
    else $error("error index out of range");
  chk_faulty_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_error && dev_error_faulty_cmd |=> $stable(err_idx_q) && $stable(err_cnt_q))
    else $error("faulty command was logged");
  chk_cnt_sat: assert property (@(posedge aclk) disable iff (!aresetn)
    err_cnt_q == 16'hFFFF |=> err_cnt_q == 16'hFFFF)
    else $error("error count wrapped");
  chk_phy_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    phy_clear && !phy_event |=> phy_cnt_q == '0)
    else $error("counter not cleared");
  chk_dir_version: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == elrh_pkg::ST_WAIT && log_q == elrh_pkg::LOG_DIR && sect_q == 16'h0000 &&
    byte_q == 9'h000 |=> log_data == elrh_pkg::DIR_VERSION[7:0])
    else $error("directory version wrong");
endmodule

/* tb/elrh_host_model.sv */
/*
  Host-side sink for the log byte stream: takes bytes with random stalls.
  Assumes it shares the design's clock and reset.
*/
`timescale 1ns/10ps
module elrh_host_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Log stream
  input wire logic log_valid,
  input wire logic [7:0] log_data,
  input wire logic log_last,
  output logic log_ready
);
  logic [8:0] got[$];
  initial log_ready = 1'b0;
  // Stalls one cycle in four so held valid and data get exercised
  always @(posedge aclk) begin
    if (aresetn && log_valid === 1'b1 && log_ready === 1'b1) begin
      got.push_back({log_last, log_data});
    end
    log_ready <= aresetn && ($urandom % 4 != 0);
  end
endmodule

/* tb/tb.sv */
/*
  Self-checking bench for the log read handler: register reads, log reads,
  refusals and error and counter events, checked against an integer model.
  Assumes the host model sinks the byte stream.
*/
`timescale 1ns/10ps
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, cmd_valid = 1'b0, cmd_phy_reset = 1'b0;
  logic [7:0] cmd_opcode = 8'h00, cmd_count_cur = 8'h00, cmd_count_prev = 8'h00;
  logic [7:0] cmd_addr_lo = 8'h00, cmd_addr_mid_cur = 8'h00, cmd_addr_mid_prev = 8'h00;
  logic dev_error = 1'b0, dev_error_faulty_cmd = 1'b0, phy_event = 1'b0;
  logic log_valid, log_last, log_ready, host_intr;
  logic [7:0] log_data, command_status_flags, command_error_flags;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_fail = 0, compares = 0, n_intr = 0, nerr = 0, phyc = 0;
  logic [31:0] rd;
  logic [1:0] rr, br;

  elrh_top dut (.aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_phy_reset(cmd_phy_reset), .cmd_count_cur(cmd_count_cur),
    .cmd_count_prev(cmd_count_prev), .cmd_addr_lo(cmd_addr_lo),
    .cmd_addr_mid_cur(cmd_addr_mid_cur), .cmd_addr_mid_prev(cmd_addr_mid_prev),
    .dev_error(dev_error), .dev_error_faulty_cmd(dev_error_faulty_cmd),
    .phy_event(phy_event), .log_valid(log_valid), .log_data(log_data), .log_last(log_last),
    .log_ready(log_ready), .host_intr(host_intr), .command_status_flags(command_status_flags),
    .command_error_flags(command_error_flags), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  elrh_host_model host (.aclk(aclk), .aresetn(aresetn), .log_valid(log_valid),
    .log_data(log_data), .log_last(log_last), .log_ready(log_ready));

  // Clock at 40 MHz
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  // Interrupt pulses counted per command
  always @(posedge aclk) begin
    if (host_intr === 1'b1) n_intr++;
  end

  task automatic conclude();
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Master holds each channel until its own handshake edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1 && !awvalid && !wvalid));
    br = bresp;
    bready <= 1'b0;
  endtask

  // Waits are ended only by the watchdog
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1 && !arvalid));
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  // Model of one log byte; -1 marks a byte not predicted
  function automatic int exp_byte(input int lg, input int i);
    int n;
    n = i / 2;
    if (i == 511 && lg != 16 && lg != 0) return -1;
    case (lg)
      0: begin
        if (i < 2) return (i == 0) ? 1 : 0;
        if (i % 2) return 0;
        if (n == 3 || n == 7 || n == 16 || n == 17) return 1;
        return (n >= 128 && n < 160) ? 16 : 0;
      end
      3: begin
        if (i == 0) return 1;
        if (i == 2) return (nerr == 0) ? 0 : ((nerr - 1) % 4) + 1;
        if (i == 500) return nerr & 255;
        if (i == 501) return nerr >> 8;
        // Every error is raised after a clean read: status ready and seek done
        if (i >= 4 && i < 500 && (i - 4) / 124 < ((nerr < 4) ? nerr : 4))
          return ((i - 4) % 124 == 101) ? 32'h0000_0050 : 0;
        return 0;
      end
      7: return (i == 0) ? 1 : 0;
      17: return (i == 2) ? (phyc & 255) : (i == 3) ? (phyc >> 8) : 0;
      default: return 0;
    endcase
  endfunction

  // Issues one command; nsec 0 expects refusal, -1 expects it ignored
  task automatic run(input logic [7:0] op, input logic [7:0] lg, input logic [15:0] cnt,
      input logic [15:0] st, input logic rst, input int nsec);
    int t, b, s;
    host.got.delete();
    n_intr = 0;
    s = 0;
    @(posedge aclk);
    cmd_opcode <= op;
    {cmd_count_prev, cmd_count_cur} <= cnt;
    cmd_addr_lo <= lg;
    {cmd_addr_mid_prev, cmd_addr_mid_cur} <= st;
    cmd_phy_reset <= rst;
    cmd_valid <= 1'b1;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    if (nsec <= 0) begin
      repeat (40) @(posedge aclk);
      check(host.got.size(), 0);
      if (nsec == 0) check({command_status_flags, command_error_flags}, 16'h4104);
      return;
    end
    t = 0;
    while (n_intr < nsec && t < 4000 * nsec) begin
      @(posedge aclk);
      t++;
    end
    repeat (4) @(posedge aclk);
    check(n_intr, nsec);
    check(host.got.size(), 512 * nsec);
    foreach (host.got[i]) begin
      b = exp_byte(lg, i % 512);
      s += host.got[i][7:0];
      if (b >= 0) check(host.got[i][7:0], b);
      check(host.got[i][8], (i % 512) == 511);
    end
    if (lg != 0) check(s % 256, 0);
    check({command_status_flags, command_error_flags}, 16'h5000);
  endtask

  task automatic pulse_err(input logic faulty);
    @(posedge aclk);
    dev_error <= 1'b1;
    dev_error_faulty_cmd <= faulty;
    @(posedge aclk);
    dev_error <= 1'b0;
    dev_error_faulty_cmd <= 1'b0;
    if (!faulty) nerr++;
  endtask

  // Watchdog sized well past the expected run
  initial begin
    repeat (90000) @(posedge aclk);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [7:0] off [5] = '{8'h03, 8'h07, 8'h10, 8'h11, 8'h80};
    int k;
    void'($urandom(25));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (adr[i]) begin
      axi_rd(adr[i]);
      check(rr, (i == 4) ? elrh_pkg::RESP_SLVERR : elrh_pkg::RESP_OKAY);
      check(rd, (i == 0) ? 32'h0000_000F : 32'h0000_0000);
    end
    run(elrh_pkg::CMD_LOG_READ, 8'h00, 16'h0001, 16'h0000, 1'b0, 1);
    run(elrh_pkg::CMD_LOG_READ, 8'h07, 16'h0001, 16'h0000, 1'b0, 1);
    run(elrh_pkg::CMD_LOG_READ, 8'h10, 16'h0001, 16'h0000, 1'b0, 1);
    // Error ring: two entries, then wrap past four with a faulty one mixed in
    repeat (2) pulse_err(1'b0);
    run(elrh_pkg::CMD_LOG_READ, 8'h03, 16'h0001, 16'h0000, 1'b0, 1);
    repeat (2) pulse_err(1'b0);
    pulse_err(1'b1);
    pulse_err(1'b0);
    run(elrh_pkg::CMD_LOG_READ, 8'h03, 16'h0001, 16'h0000, 1'b0, 1);
    axi_rd(elrh_pkg::REG_ERRINFO);
    check(rd, 32'h0001_0005);
    // Event counter: read without and then with the clear flag
    k = 1 + $urandom % 9;
    repeat (k) begin
      @(posedge aclk);
      phy_event <= 1'b1;
      @(posedge aclk);
      phy_event <= 1'b0;
    end
    phyc = k;
    run(elrh_pkg::CMD_LOG_READ, 8'h11, 16'h0001, 16'h0000, 1'b0, 1);
    run(elrh_pkg::CMD_LOG_READ, 8'h11, 16'h0001, 16'h0000, 1'b1, 1);
    axi_rd(elrh_pkg::REG_PHY);
    check(rd, 0);
    run(elrh_pkg::CMD_LOG_READ, 8'h80, 16'h0002, 16'h000E, 1'b0, 2);
    run(elrh_pkg::CMD_LOG_READ, 8'h9F, 16'h0001, 16'h000F, 1'b0, 1);
    // Refusals: unknown logs, zero count, start and span past the end
    run(elrh_pkg::CMD_LOG_READ, 8'h05, 16'h0001, 16'h0000, 1'b0, 0);
    run(elrh_pkg::CMD_LOG_READ, 8'hA0, 16'h0001, 16'h0000, 1'b0, 0);
    run(elrh_pkg::CMD_LOG_READ, 8'h00, 16'h0000, 16'h0000, 1'b0, 0);
    run(elrh_pkg::CMD_LOG_READ, 8'h00, 16'h0001, 16'h0001, 1'b0, 0);
    run(elrh_pkg::CMD_LOG_READ, 8'h80, 16'h0003, 16'h000E, 1'b0, 0);
    run(8'hEC, 8'h00, 16'h0001, 16'h0000, 1'b0, -1);
    // Feature sets switched off refuse their logs
    axi_wr(elrh_pkg::REG_CTRL, 32'h0000_0000);
    check(br, elrh_pkg::RESP_OKAY);
    foreach (off[i]) run(elrh_pkg::CMD_LOG_READ, off[i], 16'h0001, 16'h0000, 1'b0, 0);
    axi_wr(elrh_pkg::REG_CTRL, 32'h0000_000F);
    check(br, elrh_pkg::RESP_OKAY);
    // Unmapped write is refused and leaves the enables alone
    axi_wr(8'h10, 32'h0000_0000);
    check(br, elrh_pkg::RESP_SLVERR);
    axi_rd(elrh_pkg::REG_CTRL);
    check(rd, 32'h0000_000F);
    conclude();
  end
endmodule
